// ### src/sst_pkg.sv
// constants, field layouts and carrier types of the subtract/swap/tagged-add/trap execute block
// assumes a 32-bit core with 32-bit data words and byte addressing
`default_nettype none

package sst_pkg;

  // instruction classes and op3 codes
  localparam logic [1:0] OP_ARITH = 2'h2;
  localparam logic [1:0] OP_MEM   = 2'h3;
  localparam logic [5:0] OP3_SUB    = 6'h04;
  localparam logic [5:0] OP3_SUBCC  = 6'h14;
  localparam logic [5:0] OP3_SUBX   = 6'h0c;
  localparam logic [5:0] OP3_SUBXCC = 6'h1c;
  localparam logic [5:0] OP3_TADD   = 6'h20;
  localparam logic [5:0] OP3_TADDTV = 6'h22;
  localparam logic [5:0] OP3_TRAP   = 6'h3a;
  localparam logic [5:0] OP3_SWAP   = 6'h0f;
  localparam logic [5:0] OP3_SWAPA  = 6'h1f;

  // trap condition codes
  localparam logic [3:0] COND_ALWAYS   = 4'h8;
  localparam logic [3:0] COND_CARRY_CL = 4'hd;
  localparam logic [3:0] COND_CARRY_ST = 4'h5;

  // trap type values
  localparam logic [7:0] SW_TRAP_BASE = 8'h80;
  localparam logic [7:0] TYPE_ILLEGAL = 8'h01;
  localparam logic [7:0] TYPE_PRIV    = 8'h02;
  localparam logic [7:0] TYPE_ALIGN   = 8'h03;
  localparam logic [7:0] TYPE_DATA    = 8'h04;
  localparam logic [7:0] TYPE_TAG     = 8'h05;

  // address space identifiers for the plain swap
  localparam logic [7:0] SPACE_USER  = 8'h0a;
  localparam logic [7:0] SPACE_SUPER = 8'h0b;

  // register byte offsets
  localparam logic [31:0] REG_PSW  = 32'h0000_0000;
  localparam logic [31:0] REG_TBW  = 32'h0000_0004;
  localparam logic [31:0] REG_CTRL = 32'h0000_0008;
  localparam logic [31:0] REG_STAT = 32'h0000_000c;

  // field positions
  localparam int PSW_ICC_LSB   = 0;
  localparam int PSW_SUPER_BIT = 8;
  localparam int TBW_TYPE_LSB  = 4;
  localparam int TBW_TBA_LSB   = 12;
  localparam int CTRL_SVT_BIT  = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int STAT_TRAP_BIT = 2;

  // values after reset
  localparam logic [3:0]  ICC_RESET   = 4'h0;
  localparam logic        SUPER_RESET = 1'b1;
  localparam logic [19:0] TBA_RESET   = 20'h00000;
  localparam logic [7:0]  TYPE_RESET  = 8'h00;
  localparam logic        SVT_RESET   = 1'b0;

  // register select codes
  typedef enum logic [2:0] {
    SEL_PSW  = 3'h0,
    SEL_TBW  = 3'h1,
    SEL_CTRL = 3'h2,
    SEL_STAT = 3'h3,
    SEL_NONE = 3'h4
  } sst_sel_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } sst_state_t;

  typedef struct packed {
    logic [31:0] instr;
    logic [31:0] rs1_val;
    logic [31:0] rs2_val;
    logic [31:0] rd_val;
  } sst_issue_t;

  typedef struct packed {
    logic [4:0]  rd;
    logic [31:0] data;
  } sst_wb_t;

  typedef struct packed {
    logic [7:0]  ttype;
    logic [31:0] vector;
  } sst_trap_t;

  typedef struct packed {
    logic        we;
    logic        lock;
    logic [7:0]  space;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sst_mem_t;

endpackage : sst_pkg

`default_nettype wire

// ### src/sst_alu.sv
// 32-bit add/subtract with carry-in and n,z,v,c flags
// purely combinational; the caller registers results
`default_nettype none

module sst_alu (
  // operands
  input  wire logic [31:0] a,
  input  wire logic [31:0] b,
  input  wire logic        cin,
  input  wire logic        sub,
  // result and flags {n,z,v,c}
  output logic      [31:0] res,
  output logic      [3:0]  flags
);

  logic [32:0] ext;
  logic        ovf;

  always_comb begin
    if (sub) begin
      // carry out of a subtract is the borrow
      ext = {1'b0, a} - {1'b0, b} - {32'h0000_0000, cin};
      ovf = (a[31] ^ b[31]) & (ext[31] ^ a[31]);
    end else begin
      ext = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
      ovf = ~(a[31] ^ b[31]) & (ext[31] ^ a[31]);
    end
    res   = ext[31:0];
    flags = {ext[31], (ext[31:0] == 32'h0000_0000), ovf, ext[32]};
  end

endmodule : sst_alu

`default_nettype wire

// ### src/sst_exec.sv
// execute unit for subtract, swap, tagged add and software trap instructions
// assumes issue, memory and trap-pending inputs come from logic on the same clock
// Summary of operation
// - sub writes rs1 minus rs2 or immediate
// - subcc sets n z v c, signed overflow
// - subx forms also subtract carry
// - subcc writes flags and destination
// - swap exchanges rd with addressed word
// - swap read and write indivisible, locked
// - faulting swap leaves memory unmodified
// - alternate swap privileged, immediate is illegal
// - alternate swap uses register sum, instr space id
// - trap always unless higher trap pending
// - trap type is 128 plus sum low bits
// - single vector mode ignores trap type
// - tag overflow from low bits or overflow
// - tagged add sets v from tag overflow
// - trapping tagged add traps, keeps state
// - trapping tagged add otherwise clears v
// - trap on carry clear, else no-op
// - trap on carry set
`default_nettype none

module sst_exec #(
  parameter int PADDR_W = 12
) (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst_n,
  // apb slave
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // instruction issue
  input  wire logic               issue_valid,
  input  wire sst_pkg::sst_issue_t issue,
  input  wire logic               higher_trap_pending,
  output logic                    issue_ready,
  // completion
  output logic                    done,
  output logic                    wb_valid,
  output sst_pkg::sst_wb_t        wb,
  output logic                    trap_valid,
  output sst_pkg::sst_trap_t      trap,
  // data memory
  output logic                    mem_req,
  output sst_pkg::sst_mem_t       mem,
  input  wire logic               mem_ack,
  input  wire logic               mem_err,
  input  wire logic [31:0]        mem_rdata
);
  import sst_pkg::*;

  // refuse widths that cannot hold the register offsets
  if (PADDR_W < 4 || PADDR_W > 32) begin : g_width_check
    $error("PADDR_W must lie between 4 and 32");
  end

  function automatic sst_sel_t reg_sel(input logic [PADDR_W-1:0] a);
    logic [31:0] full;
    full = 32'(a);
    if (full == REG_PSW) begin
      reg_sel = SEL_PSW;
    end else if (full == REG_TBW) begin
      reg_sel = SEL_TBW;
    end else if (full == REG_CTRL) begin
      reg_sel = SEL_CTRL;
    end else if (full == REG_STAT) begin
      reg_sel = SEL_STAT;
    end else begin
      reg_sel = SEL_NONE;
    end
  endfunction : reg_sel

  // reset release through two flops
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  sst_state_t  state;
  sst_state_t  next_state;
  logic [3:0]  icc;
  logic [3:0]  next_icc;
  logic        super_mode;
  logic        next_super_mode;
  logic [19:0] tba;
  logic [19:0] next_tba;
  logic [7:0]  trap_type;
  logic [7:0]  next_trap_type;
  logic        svt_en;
  logic        next_svt_en;
  logic        last_trap;
  logic        next_last_trap;
  logic [4:0]  swap_rd;
  logic [4:0]  next_swap_rd;
  logic [31:0] swap_read;
  logic [31:0] next_swap_read;
  logic        next_done;
  logic        next_wb_valid;
  sst_wb_t     next_wb;
  logic        next_trap_valid;
  sst_trap_t   next_trap;
  logic        next_mem_req;
  sst_mem_t    next_mem;
  logic        next_pready;
  logic [31:0] next_prdata;
  logic        raise;
  logic [7:0]  raise_type;

  // instruction fields and operands
  logic [1:0]  f_op;
  logic [5:0]  f_op3;
  logic [3:0]  f_cond;
  logic        f_imm;
  logic [31:0] opb;
  logic [31:0] eff_sum;
  logic        alu_sub;
  logic        alu_cin;
  logic [31:0] alu_res;
  logic [3:0]  alu_flags;
  logic        tag_ovf;
  logic        apb_acc;
  logic        apb_wr;
  sst_sel_t    sel;

  assign f_op    = issue.instr[31:30];
  assign f_op3   = issue.instr[24:19];
  assign f_cond  = issue.instr[28:25];
  assign f_imm   = issue.instr[13];
  assign opb     = f_imm ? {{19{issue.instr[12]}}, issue.instr[12:0]} : issue.rs2_val;
  assign eff_sum = issue.rs1_val + opb;
  assign alu_sub = !(f_op3 == OP3_TADD || f_op3 == OP3_TADDTV);
  assign alu_cin = (f_op3 == OP3_SUBX || f_op3 == OP3_SUBXCC) ? icc[0] : 1'b0;

  sst_alu u_alu (
    .a     (issue.rs1_val),
    .b     (opb),
    .cin   (alu_cin),
    .sub   (alu_sub),
    .res   (alu_res),
    .flags (alu_flags)
  );

  assign tag_ovf = (|issue.rs1_val[1:0]) | (|opb[1:0]) | alu_flags[1];

  assign issue_ready = (state == ST_IDLE);
  assign apb_acc     = psel & penable;
  assign apb_wr      = apb_acc & pready & pwrite;
  assign sel         = reg_sel(paddr);
  assign pslverr     = apb_acc & pready & (sel == SEL_NONE);

  // apb: one wait state so read data comes from a flop
  always_comb begin
    next_pready = apb_acc & !pready;
    next_prdata = prdata;
    if (apb_acc && !pready) begin
      next_prdata = 32'h0000_0000;
      unique case (sel)
        SEL_PSW: begin
          next_prdata[PSW_ICC_LSB +: 4] = icc;
          next_prdata[PSW_SUPER_BIT]    = super_mode;
        end
        SEL_TBW: begin
          next_prdata[TBW_TBA_LSB +: 20] = tba;
          next_prdata[TBW_TYPE_LSB +: 8] = trap_type;
        end
        SEL_CTRL: begin
          next_prdata[CTRL_SVT_BIT] = svt_en;
        end
        SEL_STAT: begin
          next_prdata[STAT_BUSY_BIT] = (state != ST_IDLE);
          next_prdata[STAT_LOCK_BIT] = mem.lock;
          next_prdata[STAT_TRAP_BIT] = last_trap;
        end
        SEL_NONE: begin
          next_prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= next_pready;
      prdata <= next_prdata;
    end
  end

  // execute and architectural state; execution wins over a same-cycle write
  always_comb begin
    next_state      = state;
    next_icc        = icc;
    next_super_mode = super_mode;
    next_tba        = tba;
    next_trap_type  = trap_type;
    next_svt_en     = svt_en;
    next_last_trap  = last_trap;
    next_swap_rd    = swap_rd;
    next_swap_read  = swap_read;
    next_done       = 1'b0;
    next_wb_valid   = 1'b0;
    next_wb         = wb;
    next_trap_valid = 1'b0;
    next_trap       = trap;
    next_mem_req    = mem_req;
    next_mem        = mem;
    raise           = 1'b0;
    raise_type      = TYPE_RESET;
    if (apb_wr) begin
      unique case (sel)
        SEL_PSW: begin
          next_icc        = pwdata[PSW_ICC_LSB +: 4];
          next_super_mode = pwdata[PSW_SUPER_BIT];
        end
        SEL_TBW: begin
          next_tba = pwdata[TBW_TBA_LSB +: 20];
          next_trap_type = pwdata[TBW_TYPE_LSB +: 8];
        end
        SEL_CTRL: next_svt_en = pwdata[CTRL_SVT_BIT];
        SEL_STAT, SEL_NONE: begin
        end
      endcase
    end
    unique case (state)
      ST_IDLE: begin
        if (issue_valid) begin
          next_done   = 1'b1;
          next_wb.rd  = issue.instr[29:25];
          next_wb.data = alu_res;
          if (f_op == OP_ARITH) begin
            case (f_op3)
              OP3_SUB, OP3_SUBX: next_wb_valid = 1'b1;
              OP3_SUBCC, OP3_SUBXCC: begin
                next_wb_valid = 1'b1;
                next_icc      = alu_flags;
              end
              OP3_TADD: begin
                next_wb_valid = 1'b1;
                next_icc      = {alu_flags[3:2], tag_ovf, alu_flags[0]};
              end
              OP3_TADDTV: begin
                if (tag_ovf) begin
                  raise    = 1'b1;
                  raise_type = TYPE_TAG;
                end else begin
                  next_wb_valid = 1'b1;
                  next_icc      = {alu_flags[3:2], 1'b0, alu_flags[0]};
                end
              end
              OP3_TRAP: begin
                if (f_cond == COND_ALWAYS || (f_cond == COND_CARRY_CL && !icc[0])
                    || (f_cond == COND_CARRY_ST && icc[0])) begin
                  if (!higher_trap_pending) begin
                    raise    = 1'b1;
                    raise_type = SW_TRAP_BASE | {1'b0, eff_sum[6:0]};
                  end
                end else if (f_cond != COND_CARRY_CL && f_cond != COND_CARRY_ST) begin
                  raise      = 1'b1;
                  raise_type = TYPE_ILLEGAL;
                end
              end
              default: begin
                raise      = 1'b1;
                raise_type = TYPE_ILLEGAL;
              end
            endcase
          end else if (f_op == OP_MEM && f_op3 == OP3_SWAP) begin
            if (eff_sum[1:0] != 2'h0) begin
              raise      = 1'b1;
              raise_type = TYPE_ALIGN;
            end else begin
              next_done     = 1'b0;
              next_mem_req  = 1'b1;
              next_mem.we   = 1'b0;
              next_mem.lock = 1'b1;
              next_mem.addr = eff_sum;
              next_mem.space = super_mode ? SPACE_SUPER : SPACE_USER;
              next_mem.wdata = issue.rd_val;
              next_swap_rd  = issue.instr[29:25];
              next_state    = ST_READ;
            end
          end else if (f_op == OP_MEM && f_op3 == OP3_SWAPA) begin
            if (f_imm) begin
              raise      = 1'b1;
              raise_type = TYPE_ILLEGAL;
            end else if (!super_mode) begin
              raise      = 1'b1;
              raise_type = TYPE_PRIV;
            end else if (eff_sum[1:0] != 2'h0) begin
              raise      = 1'b1;
              raise_type = TYPE_ALIGN;
            end else begin
              // register sum, space id from the instruction
              next_done     = 1'b0;
              next_mem_req  = 1'b1;
              next_mem.we   = 1'b0;
              next_mem.lock = 1'b1;
              next_mem.addr = eff_sum;
              next_mem.space = issue.instr[12:5];
              next_mem.wdata = issue.rd_val;
              next_swap_rd  = issue.instr[29:25];
              next_state    = ST_READ;
            end
          end else begin
            raise      = 1'b1;
            raise_type = TYPE_ILLEGAL;
          end
        end
      end
      ST_READ: begin
        if (mem_ack) begin
          if (mem_err) begin
            raise         = 1'b1;
            raise_type    = TYPE_DATA;
            next_done     = 1'b1;
            next_mem_req  = 1'b0;
            next_mem.lock = 1'b0;
            next_state    = ST_IDLE;
          end else begin
            next_swap_read = mem_rdata;
            next_mem.we    = 1'b1;
            next_state     = ST_WRITE;
          end
        end
      end
      ST_WRITE: begin
        if (mem_ack) begin
          next_done     = 1'b1;
          next_mem_req  = 1'b0;
          next_mem.lock = 1'b0;
          next_mem.we   = 1'b0;
          next_state    = ST_IDLE;
          if (mem_err) begin
            raise    = 1'b1;
            raise_type = TYPE_DATA;
          end else begin
            next_wb_valid = 1'b1;
            next_wb.rd    = swap_rd;
            next_wb.data  = swap_read;
          end
        end
      end
    endcase
    if (raise) begin
      next_trap_valid = 1'b1;
      next_trap.ttype = raise_type;
      next_trap_type  = raise_type;
      next_trap.vector = svt_en ? {tba, 12'h000} : {tba, raise_type, 4'h0};
      next_last_trap  = 1'b1;
    end else if (next_done) begin
      next_last_trap = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state      <= ST_IDLE;
      icc        <= ICC_RESET;
      super_mode <= SUPER_RESET;
      tba        <= TBA_RESET;
      trap_type  <= TYPE_RESET;
      svt_en     <= SVT_RESET;
      last_trap  <= 1'b0;
      swap_rd    <= 5'h00;
      swap_read  <= 32'h0000_0000;
      done       <= 1'b0;
      wb_valid   <= 1'b0;
      wb         <= '0;
      trap_valid <= 1'b0;
      trap       <= '0;
      mem_req    <= 1'b0;
      mem        <= '0;
    end else begin
      state      <= next_state;
      icc        <= next_icc;
      super_mode <= next_super_mode;
      tba        <= next_tba;
      trap_type  <= next_trap_type;
      svt_en     <= next_svt_en;
      last_trap  <= next_last_trap;
      swap_rd    <= next_swap_rd;
      swap_read  <= next_swap_read;
      done       <= next_done;
      wb_valid   <= next_wb_valid;
      wb         <= next_wb;
      trap_valid <= next_trap_valid;
      trap       <= next_trap;
      mem_req    <= next_mem_req;
      mem        <= next_mem;
    end
  end

endmodule : sst_exec

`default_nettype wire

// ### dv/sst_props.sv
// assertions on the ports of the execute block
// bound into sst_exec from the bench top; sees ports only
`default_nettype none

module sst_props
  import sst_pkg::*;
#(
  parameter int PADDR_W = 12
) (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  // apb
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  // issue and completion
  input wire logic       issue_valid,
  input wire sst_issue_t issue,
  input wire logic       higher_trap_pending,
  input wire logic       issue_ready,
  input wire logic       done,
  input wire logic       wb_valid,
  input wire sst_wb_t    wb,
  input wire logic       trap_valid,
  input wire sst_trap_t  trap,
  // memory
  input wire logic       mem_req,
  input wire sst_mem_t   mem,
  input wire logic       mem_ack,
  input wire logic       mem_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] op2;
  logic [31:0] sum;
  logic        acc;
  logic [5:0]  op3;
  assign op2 = issue.instr[13] ? {{19{issue.instr[12]}}, issue.instr[12:0]} : issue.rs2_val;
  assign sum = issue.rs1_val + op2;
  assign op3 = issue.instr[24:19];
  assign acc = issue_valid && issue_ready && issue.instr[31:30] == OP_ARITH;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_rd_ok;
    mem_req && !mem.we && mem_ack && !mem_err;
  endsequence
  sequence s_wr;
    mem_req && mem.we && mem.lock;
  endsequence

  chk_apb_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("apb answer not one wait state");
  chk_apb_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_arith_done: assert property (acc |=> done)
    else $error("arith op not done next cycle");
  chk_sub_diff: assert property (acc && op3 == OP3_SUB |=> wb_valid &&
    wb.data == $past(issue.rs1_val - op2) && wb.rd == $past(issue.instr[29:25]))
    else $error("sub result wrong");
  chk_tag_trap: assert property (acc && op3 == OP3_TADDTV &&
    (issue.rs1_val[1:0] != 2'h0 || op2[1:0] != 2'h0) |=> trap_valid && trap.ttype == TYPE_TAG)
    else $error("tag overflow trap missing");
  chk_sw_type: assert property (acc && op3 == OP3_TRAP &&
    issue.instr[28:25] == COND_ALWAYS && !higher_trap_pending
    |=> trap_valid && trap.ttype == {1'b1, $past(sum[6:0])})
    else $error("software trap type wrong");
  chk_trap_held: assert property (acc && op3 == OP3_TRAP &&
    issue.instr[28:25] == COND_ALWAYS && higher_trap_pending |=> done && !trap_valid)
    else $error("trap taken while higher pending");
  chk_trap_only: assert property (trap_valid |-> done && !wb_valid)
    else $error("trap with writeback");
  chk_swap_pair: assert property (s_rd_ok |=> s_wr)
    else $error("swap write not locked after read");
  chk_lock_start: assert property ($rose(mem_req) |-> mem.lock && !mem.we)
    else $error("swap not starting locked read");
  chk_err_nowr: assert property (mem_req && !mem.we && mem_ack && mem_err |=> !mem_req)
    else $error("write after faulting read");
  chk_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem))
    else $error("memory request not held");
endmodule : sst_props

`default_nettype wire

// ### dv/sst_exec_tb.sv
// self-checking bench for sst_exec: apb registers, alu, traps, swap
// the bench answers the memory port itself; checker bound below
`default_nettype none

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("Error at %0t got %h expected %h", $time, (g), (e)); end end

module sst_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sst_pkg::*;

  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        issue_valid, higher_trap_pending, issue_ready, done, wb_valid, trap_valid;
  logic        mem_req, mem_ack, mem_err, err_mode, rd_e, r_wb, r_tv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mem_rdata, mem_word, last_addr, rd_q, r_d, r_vec;
  logic [7:0]  last_space, r_type;
  sst_issue_t  issue;
  sst_wb_t     wb;
  sst_trap_t   trap;
  sst_mem_t    mem;
  int          n_fail = 0, cmp_count = 0, cyc = 0, n_acc = 0, k;

  sst_exec i_dut (.clock, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .issue_valid, .issue, .higher_trap_pending, .issue_ready, .done,
    .wb_valid, .wb, .trap_valid, .trap, .mem_req, .mem, .mem_ack, .mem_err, .mem_rdata);

  always #5 clock = ~clock;

  // memory answers one cycle late; data lines toggle outside the ack cycle
  always @(posedge clock) begin
    mem_ack <= 1'b0;
    mem_err <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req === 1'b1 && mem_ack === 1'b0) begin
      mem_ack <= 1'b1;
      mem_err <= err_mode;
      mem_rdata <= mem_word;
      last_addr <= mem.addr;
      last_space <= mem.space;
      n_acc++;
      if (mem.we === 1'b1 && !err_mode) mem_word <= mem.wdata;
    end
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_of_test;
    end
  end

  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    // one idle edge first, so psel never gets two values in one time step
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a[11:0];
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // answer taken at the edge that samples pready high; watchdog ends a hang
    do @(posedge clock); while (pready !== 1'b1);
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic psw_is(input logic [31:0] e);
    apb(1'b0, REG_PSW, 32'h0);
    `CHK(rd_q, e)
  endtask : psw_is

  task automatic run(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b,
                     input logic [31:0] r);
    issue_valid <= 1'b1;
    issue <= '{ins, a, b, r};
    @(posedge clock);
    issue_valid <= 1'b0;
    // results are taken at the edge that samples done high
    do @(posedge clock); while (done !== 1'b1);
    r_wb = wb_valid;
    r_d = wb.data;
    r_tv = trap_valid;
    r_type = trap.ttype;
    r_vec = trap.vector;
  endtask : run

  function automatic logic [31:0] fa(logic [5:0] o, logic i, logic [12:0] low);
    return {OP_ARITH, 5'h03, o, 5'h00, i, low};
  endfunction : fa

  function automatic logic [31:0] ft(logic [3:0] c, logic i, logic [12:0] low);
    return {OP_ARITH, 1'b0, c, OP3_TRAP, 5'h00, i, low};
  endfunction : ft

  function automatic logic [31:0] fs(logic [5:0] o, logic i, logic [12:0] low);
    return {OP_MEM, 5'h03, o, 5'h00, i, low};
  endfunction : fs

  task automatic t_regs;
    psw_is(32'h0000_0100);
    apb(1'b0, 32'h10, 32'h0);
    `CHK(rd_e, 1'b1)
    `CHK(rd_q, 32'h0)
    apb(1'b1, REG_TBW, 32'h1234_5000);
    apb(1'b0, REG_TBW, 32'h0);
    `CHK(rd_q, 32'h1234_5000)
  endtask : t_regs

  task automatic t_sub;
    run(fa(OP3_SUBCC, 1'b1, 13'h0007), 32'h4, 32'h0, 32'h0);
    `CHK(r_d, 32'hffff_fffd)
    `CHK(wb.rd, 5'h03)
    psw_is(32'h0000_0109);
    run(fa(OP3_SUB, 1'b1, 13'h1ffe), 32'h4, 32'h0, 32'h0);
    `CHK(r_d, 32'h6)
    run(fa(OP3_SUBX, 1'b0, 13'h0), 32'h4, 32'h2, 32'h0);
    `CHK(r_d, 32'h1)
    psw_is(32'h0000_0109);
    apb(1'b1, REG_PSW, 32'h0000_0104);
    run(fa(OP3_SUBXCC, 1'b0, 13'h0), 32'h7fff_ffff, 32'hffff_ffff, 32'h0);
    `CHK(r_d, 32'h8000_0000)
    psw_is(32'h0000_010b);
    run(fa(OP3_SUBXCC, 1'b0, 13'h0), 32'h7fff_ffff, 32'hffff_ffff, 32'h0);
    `CHK(r_d, 32'h7fff_ffff)
    psw_is(32'h0000_0101);
  endtask : t_sub

  task automatic t_tadd;
    apb(1'b1, REG_PSW, 32'h0000_0100);
    run(fa(OP3_TADD, 1'b1, 13'h0001), 32'h0, 32'h0, 32'h0);
    `CHK(r_d, 32'h1)
    psw_is(32'h0000_0102);
    run(fa(OP3_TADD, 1'b0, 13'h0), 32'h7fff_fffc, 32'h4, 32'h0);
    `CHK(r_d, 32'h8000_0000)
    psw_is(32'h0000_010a);
    run(fa(OP3_TADDTV, 1'b1, 13'h0001), 32'h0, 32'h0, 32'h0);
    `CHK(r_type, TYPE_TAG)
    `CHK(r_wb, 1'b0)
    psw_is(32'h0000_010a);
    run(fa(OP3_TADDTV, 1'b0, 13'h0), 32'h4, 32'h8, 32'h0);
    `CHK(r_d, 32'hc)
    psw_is(32'h0000_0100);
  endtask : t_tadd

  task automatic t_trap;
    run(ft(COND_ALWAYS, 1'b1, 13'd35), 32'h0, 32'h0, 32'h0);
    `CHK(r_type, 8'ha3)
    `CHK(r_vec, 32'h1234_5a30)
    apb(1'b0, REG_STAT, 32'h0);
    `CHK(rd_q, 32'h0000_0004)
    apb(1'b0, REG_TBW, 32'h0);
    `CHK(rd_q, 32'h1234_5a30)
    run(ft(COND_CARRY_CL, 1'b1, 13'd33), 32'h0, 32'h0, 32'h0);
    `CHK(r_type, 8'ha1)
    run(ft(COND_CARRY_ST, 1'b1, 13'd33), 32'h0, 32'h0, 32'h0);
    `CHK(r_tv, 1'b0)
    apb(1'b1, REG_PSW, 32'h0000_0101);
    run(ft(COND_CARRY_ST, 1'b0, 13'h0), 32'h100, 32'h22, 32'h0);
    `CHK(r_type, 8'ha2)
    run(ft(COND_CARRY_CL, 1'b1, 13'd33), 32'h0, 32'h0, 32'h0);
    `CHK(r_tv, 1'b0)
    `CHK(r_wb, 1'b0)
    psw_is(32'h0000_0101);
    higher_trap_pending <= 1'b1;
    run(ft(COND_ALWAYS, 1'b1, 13'd35), 32'h0, 32'h0, 32'h0);
    `CHK(r_tv, 1'b0)
    higher_trap_pending <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h1);
    run(ft(COND_ALWAYS, 1'b1, 13'd36), 32'h0, 32'h0, 32'h0);
    `CHK(r_vec, 32'h1234_5000)
    apb(1'b1, REG_CTRL, 32'h0);
  endtask : t_trap

  task automatic t_swap;
    run(fs(OP3_SWAP, 1'b1, 13'h0004), 32'h100, 32'h0, 32'h1111_2222);
    `CHK(r_d, 32'hcafe_f00d)
    `CHK(mem_word, 32'h1111_2222)
    `CHK(last_addr, 32'h104)
    `CHK(last_space, SPACE_SUPER)
    err_mode <= 1'b1;
    run(fs(OP3_SWAP, 1'b1, 13'h0004), 32'h100, 32'h0, 32'h33);
    `CHK(r_type, TYPE_DATA)
    `CHK(mem_word, 32'h1111_2222)
    err_mode <= 1'b0;
    k = n_acc;
    run(fs(OP3_SWAP, 1'b1, 13'h0002), 32'h100, 32'h0, 32'h44);
    `CHK(r_type, TYPE_ALIGN)
    run(fs(OP3_SWAPA, 1'b1, 13'h0004), 32'h100, 32'h0, 32'h44);
    `CHK(r_type, TYPE_ILLEGAL)
    `CHK(n_acc, k)
    run(fs(OP3_SWAPA, 1'b0, {8'h0f, 5'h00}), 32'h200, 32'h8, 32'h55);
    `CHK(last_space, 8'h0f)
    `CHK(last_addr, 32'h208)
    `CHK(mem_word, 32'h55)
    apb(1'b1, REG_PSW, 32'h0);
    run(fs(OP3_SWAPA, 1'b0, {8'h0f, 5'h00}), 32'h200, 32'h8, 32'h66);
    `CHK(r_type, TYPE_PRIV)
    run(fs(OP3_SWAP, 1'b0, 13'h0), 32'h300, 32'h4, 32'h77);
    `CHK(last_space, SPACE_USER)
    `CHK(r_d, 32'h55)
  endtask : t_swap

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, issue_valid, higher_trap_pending, err_mode} = '0;
    {mem_ack, mem_err} = '0;
    paddr = '0;
    pwdata = '0;
    issue = '0;
    mem_rdata = '0;
    mem_word = 32'hcafe_f00d;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_regs;
    t_sub;
    t_tadd;
    t_trap;
    t_swap;
    end_of_test;
  end
endmodule : sst_exec_tb

bind sst_exec sst_props #(.PADDR_W(PADDR_W)) i_props (.clock, .rst_n, .psel, .penable,
  .pready, .issue_valid, .issue, .higher_trap_pending, .issue_ready, .done, .wb_valid,
  .wb, .trap_valid, .trap, .mem_req, .mem, .mem_ack, .mem_err);

`undef CHK
`default_nettype wire
